// File: common/flash_erase_map.svh
// constants for the serial flash erase command block
`ifndef FLASH_ERASE_MAP_SVH
`define FLASH_ERASE_MAP_SVH

`define FE_OP_PAGE_ERASE    8'h81
`define FE_OP_BLOCK_ERASE   8'h50
`define FE_OP_SECTOR_ERASE  8'h7C
`define FE_CMD_BITS         6'h20
`define FE_CMD_LAST_BIT     6'h1F
`define FE_P264_PAGE_MSB    18
`define FE_P264_PAGE_LSB    9
`define FE_P256_PAGE_MSB    17
`define FE_P256_PAGE_LSB    8
`define FE_NUM_PAGES        1024
`define FE_BLOCK_LAST_OFS   10'h007
`define FE_SEC0A_LAST_PAGE  10'h007
`define FE_SEC0B_FIRST_PAGE 10'h008
`define FE_SEC0B_LAST_PAGE  10'h07F
`define FE_CLK_MHZ          200
`define FE_PAGE_ERASE_US    10000
`define FE_BLOCK_ERASE_US   20000
`define FE_SECTOR_ERASE_US  40000
`define FE_READY_RST        1'b1
`define FE_EPE_RST          1'b0

`endif

// File: common/flash_erase_pkg.sv
// types shared by the erase command logic
package flash_erase_pkg;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [23:0] addr;
    } cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ERASE = 2'b01,
        ST_WAIT  = 2'b11
    } state_t;

    typedef enum logic [1:0] {
        KIND_NONE   = 2'b00,
        KIND_PAGE   = 2'b01,
        KIND_BLOCK  = 2'b10,
        KIND_SECTOR = 2'b11
    } kind_t;

endpackage

// File: hdl/spi_cmd_shift.sv
// serial clock side: collects opcode and three address bytes
`timescale 1ns/1ps
`default_nettype none
`include "flash_erase_map.svh"

module spi_cmd_shift (
    input  wire logic                  sck_i,
    input  wire logic                  cs_n_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  si_i,
    output flash_erase_pkg::cmd_t      cmd_o,
    output logic                       cmd_valid_o
);
    logic [5:0]  bit_cnt;
    logic [30:0] shreg;

    // frame signal ends the count, so no edge after the frame is needed
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bit_cnt <= 6'h00;
        end else if (bit_cnt != `FE_CMD_BITS) begin
            bit_cnt <= bit_cnt + 6'h01;
        end
    end

    // word stays frozen after the frame; the core samples it then
    always_ff @(posedge sck_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shreg       <= 31'h00000000;
            cmd_o       <= '0;
            cmd_valid_o <= 1'b0;
        end else begin
            shreg <= {shreg[29:0], si_i};
            if (bit_cnt == `FE_CMD_LAST_BIT) begin
                cmd_o       <= {shreg, si_i};
                cmd_valid_o <= 1'b1;
            end else if (bit_cnt == 6'h00) begin
                cmd_valid_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: hdl/flash_erase_ctrl.sv
// erase command decode, self-timed erase sequencer and status flags
`timescale 1ns/1ps
`default_nettype none
`include "flash_erase_map.svh"

module flash_erase_ctrl #(
    parameter int unsigned PAGE_ERASE_CYCLES   = `FE_PAGE_ERASE_US * `FE_CLK_MHZ,
    parameter int unsigned BLOCK_ERASE_CYCLES  = `FE_BLOCK_ERASE_US * `FE_CLK_MHZ,
    parameter int unsigned SECTOR_ERASE_CYCLES = `FE_SECTOR_ERASE_US * `FE_CLK_MHZ
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  sck_i,
    input  wire logic                  cs_n_i,
    input  wire logic                  si_i,
    input  wire logic                  page_264_i,
    input  wire logic                  erase_verify_fail_i,
    input  wire logic [9:0]            page_query_i,
    output logic                       ready_o,
    output logic                       erase_program_error_flag_o,
    output logic                       erase_strobe_o,
    output logic [9:0]                 erase_page_o,
    output flash_erase_pkg::kind_t     erase_kind_o,
    output logic                       page_erased_o
);
    flash_erase_pkg::cmd_t   link_cmd;
    logic                    link_valid;
    logic                    cs_meta;
    logic                    cs_sync;
    logic                    cs_prev;
    logic                    opt_meta;
    logic                    opt_264;
    flash_erase_pkg::state_t state;
    logic [9:0]              page_ptr;
    logic [9:0]              last_page;
    logic [31:0]             timer;
    logic                    erased_map [`FE_NUM_PAGES];
    logic [31:0]             busy_cnt;
    logic [31:0]             busy_limit;

    spi_cmd_shift u_shift (
        .sck_i       (sck_i),
        .cs_n_i      (cs_n_i),
        .reset_n_i   (reset_n_i),
        .si_i        (si_i),
        .cmd_o       (link_cmd),
        .cmd_valid_o (link_valid)
    );

    // chip select and page option pass two flops before use
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cs_meta  <= 1'b1;
            cs_sync  <= 1'b1;
            cs_prev  <= 1'b1;
            opt_meta <= 1'b0;
            opt_264  <= 1'b0;
        end else begin
            cs_meta  <= cs_n_i;
            cs_sync  <= cs_meta;
            cs_prev  <= cs_sync;
            opt_meta <= page_264_i;
            opt_264  <= opt_meta;
        end
    end

    // command word is still once the frame is over, so the synced edge qualifies it
    wire cs_rise = cs_sync & ~cs_prev;

    wire [9:0] page_264 = link_cmd.addr[`FE_P264_PAGE_MSB:`FE_P264_PAGE_LSB];
    wire [9:0] page_256 = link_cmd.addr[`FE_P256_PAGE_MSB:`FE_P256_PAGE_LSB];
    wire [9:0] page_num = opt_264 ? page_264 : page_256;

    wire is_page   = link_cmd.opcode == `FE_OP_PAGE_ERASE;
    wire is_block  = link_cmd.opcode == `FE_OP_BLOCK_ERASE;
    wire is_sector = link_cmd.opcode == `FE_OP_SECTOR_ERASE;
    wire is_erase  = is_page | is_block | is_sector;

    // block number is page bits 9..3 in both options
    wire [9:0] block_first = {page_num[9:3], 3'b000};
    wire [9:0] block_last  = block_first | `FE_BLOCK_LAST_OFS;

    // upper sectors use bits 9..7, sector 0 splits on bits 6..3
    wire       sec_hi    = page_num[9:7] != 3'b000;
    wire       sec_0a    = page_num[9:3] == 7'h00;
    wire [9:0] sec_first = sec_hi ? {page_num[9:7], 7'h00}
                         : (sec_0a ? 10'h000 : `FE_SEC0B_FIRST_PAGE);
    wire [9:0] sec_last  = sec_hi ? {page_num[9:7], 7'h7F}
                         : (sec_0a ? `FE_SEC0A_LAST_PAGE : `FE_SEC0B_LAST_PAGE);

    wire [9:0] next_first = is_page ? page_num : (is_block ? block_first : sec_first);
    wire [9:0] next_last  = is_page ? page_num : (is_block ? block_last : sec_last);
    wire [31:0] next_cycles = is_page  ? 32'(PAGE_ERASE_CYCLES)
                            : is_block ? 32'(BLOCK_ERASE_CYCLES)
                            : 32'(SECTOR_ERASE_CYCLES);
    wire flash_erase_pkg::kind_t next_kind = is_page  ? flash_erase_pkg::KIND_PAGE
                                           : is_block ? flash_erase_pkg::KIND_BLOCK
                                           : flash_erase_pkg::KIND_SECTOR;

    // commands arriving while busy are dropped; host must poll first
    wire start     = cs_rise & link_valid & is_erase & (state == flash_erase_pkg::ST_IDLE);
    wire erase_now = state == flash_erase_pkg::ST_ERASE;
    wire at_last   = page_ptr == last_page;
    wire timer_end = timer == 32'h00000000;
    wire fail_seen = erase_strobe_o & erase_verify_fail_i;

    // sequencer: one page per cycle, busy held until the erase time counted from start runs out
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state     <= flash_erase_pkg::ST_IDLE;
            page_ptr  <= 10'h000;
            last_page <= 10'h000;
            timer     <= 32'h00000000;
            ready_o   <= `FE_READY_RST;
        end else begin
            case (state)
                flash_erase_pkg::ST_IDLE: begin
                    if (start) begin
                        state     <= flash_erase_pkg::ST_ERASE;
                        page_ptr  <= next_first;
                        last_page <= next_last;
                        timer     <= next_cycles - 32'h00000001;
                        ready_o   <= 1'b0;
                    end
                end
                flash_erase_pkg::ST_ERASE: begin
                    if (!timer_end) begin
                        timer <= timer - 32'h00000001;
                    end
                    if (at_last) begin
                        state <= flash_erase_pkg::ST_WAIT;
                    end else begin
                        page_ptr <= page_ptr + 10'h001;
                    end
                end
                flash_erase_pkg::ST_WAIT: begin
                    if (timer_end) begin
                        state   <= flash_erase_pkg::ST_IDLE;
                        ready_o <= 1'b1;
                    end else begin
                        timer <= timer - 32'h00000001;
                    end
                end
                default: begin
                    state   <= flash_erase_pkg::ST_IDLE;
                    ready_o <= 1'b1;
                end
            endcase
        end
    end

    // array strobe one page per cycle; verdict is taken in the same cycle as the strobe
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            erase_strobe_o <= 1'b0;
            erase_page_o   <= 10'h000;
            erase_kind_o   <= flash_erase_pkg::KIND_NONE;
        end else begin
            erase_strobe_o <= erase_now;
            erase_page_o   <= page_ptr;
            if (start) begin
                erase_kind_o <= next_kind;
            end else if (ready_o) begin
                erase_kind_o <= flash_erase_pkg::KIND_NONE;
            end
        end
    end

    // error flag reflects the latest erase; a late verdict beats the clear
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            erase_program_error_flag_o <= `FE_EPE_RST;
        end else if (fail_seen) begin
            erase_program_error_flag_o <= 1'b1;
        end else if (start) begin
            erase_program_error_flag_o <= 1'b0;
        end
    end

    // erased state per page; programming is outside this block
    for (genvar g = 0; g < `FE_NUM_PAGES; g++) begin : g_map
        always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                erased_map[g] <= 1'b0;
            end else if (erase_now && page_ptr == 10'(g)) begin
                erased_map[g] <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            page_erased_o <= 1'b0;
        end else begin
            page_erased_o <= erased_map[page_query_i];
        end
    end

    // helper: busy length against the time loaded at start
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_cnt   <= 32'h00000000;
            busy_limit <= 32'h00000000;
        end else begin
            busy_cnt <= ready_o ? 32'h00000000 : busy_cnt + 32'h00000001;
            if (start) begin
                busy_limit <= next_cycles;
            end
        end
    end

    property p_start_busy;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        start |=> !ready_o && state == flash_erase_pkg::ST_ERASE;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("erase start did not go busy");

    property p_page_264;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        start && is_page && opt_264 |=> page_ptr == $past(link_cmd.addr[18:9])
                                      && last_page == page_ptr;
    endproperty
    a_page_264: assert property (p_page_264) else $error("264 page erase wrong page");

    property p_page_256;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        start && is_page && !opt_264 |=> page_ptr == $past(link_cmd.addr[17:8])
                                       && last_page == page_ptr;
    endproperty
    a_page_256: assert property (p_page_256) else $error("256 page erase wrong page");

    property p_block_span;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        start && is_block |=> page_ptr[2:0] == 3'b000 && last_page == (page_ptr | 10'h007)
                            && page_ptr[9:3] == $past(page_num[9:3]);
    endproperty
    a_block_span: assert property (p_block_span) else $error("block range wrong");

    property p_sector_hi;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        start && is_sector && sec_hi |=> page_ptr[6:0] == 7'h00 && last_page[6:0] == 7'h7F
                                       && page_ptr[9:7] == last_page[9:7];
    endproperty
    a_sector_hi: assert property (p_sector_hi) else $error("upper sector range wrong");

    property p_sector_0a;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        start && is_sector && sec_0a |=> page_ptr == 10'h000 && last_page == 10'h007;
    endproperty
    a_sector_0a: assert property (p_sector_0a) else $error("sector 0a range wrong");

    property p_busy_bound;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        !ready_o |-> busy_cnt < busy_limit;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("busy beyond erase time");

    property p_fail_flag;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        fail_seen |=> erase_program_error_flag_o [*2];
    endproperty
    a_fail_flag: assert property (p_fail_flag) else $error("erase failure not flagged");

    property p_page_erased;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        erase_now |=> erased_map[$past(page_ptr)] && erase_strobe_o;
    endproperty
    a_page_erased: assert property (p_page_erased) else $error("page not marked erased");

    property p_block_len;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        start && is_block |=> erase_now [*8] ##1 !erase_now;
    endproperty
    a_block_len: assert property (p_block_len) else $error("block not eight pages");

    property p_ignore_busy;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        cs_rise && !ready_o |=> $stable(last_page);
    endproperty
    a_ignore_busy: assert property (p_ignore_busy) else $error("command taken while busy");
endmodule
`default_nettype wire

// File: dv/spi_host_model.sv
// serial host model: frames erase commands onto the link
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o
);
    localparam time HALF = 24ns;

    initial begin
        sck_o  = 1'b0;
        cs_n_o = 1'b0;
        si_o   = 1'b0;
        #1 cs_n_o = 1'b1; // clean rising edge after time zero clears the link bit counter
    end

    // opcode then address, msb first; clock idles low outside frames
    task automatic frame(input logic [31:0] word, input int nbits);
        #7; // phase unrelated to the core clock
        cs_n_o = 1'b0;
        for (int i = 31; i > 31 - nbits; i--) begin
            si_o = word[i];
            #HALF sck_o = 1'b1;
            #HALF sck_o = 1'b0;
        end
        #HALF cs_n_o = 1'b1;
        si_o = ~si_o; // released line must not hold its last value
    endtask
endmodule

`default_nettype wire

// File: dv/tb.sv
// self-checking bench for the erase command sequencer
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); \
        end \
    end

module tb;
    localparam int unsigned PAGE_N   = 200;
    localparam int unsigned BLOCK_N  = 300;
    localparam int unsigned SECTOR_N = 800; // long enough for a frame to land while busy

    logic                   ref_clk_i           = 1'b0;
    logic                   reset_n_i           = 1'b1;
    logic                   page_264_i          = 1'b0;
    logic                   erase_verify_fail_i = 1'b0;
    logic [9:0]             page_query_i        = 10'h000;
    wire logic              sck;
    wire logic              cs_n;
    wire logic              si;
    logic                   ready_o;
    logic                   flag_o;
    logic                   erase_strobe_o;
    logic [9:0]             erase_page_o;
    flash_erase_pkg::kind_t erase_kind_o;
    logic                   page_erased_o;
    int                     failures        = 0;
    int                     samples_checked = 0;
    int                     cycles          = 0;

    flash_erase_ctrl #(
        .PAGE_ERASE_CYCLES  (PAGE_N),
        .BLOCK_ERASE_CYCLES (BLOCK_N),
        .SECTOR_ERASE_CYCLES(SECTOR_N)
    ) i_flash_erase_ctrl (
        .ref_clk_i                 (ref_clk_i),
        .reset_n_i                 (reset_n_i),
        .sck_i                     (sck),
        .cs_n_i                    (cs_n),
        .si_i                      (si),
        .page_264_i                (page_264_i),
        .erase_verify_fail_i       (erase_verify_fail_i),
        .page_query_i              (page_query_i),
        .ready_o                   (ready_o),
        .erase_program_error_flag_o(flag_o),
        .erase_strobe_o            (erase_strobe_o),
        .erase_page_o              (erase_page_o),
        .erase_kind_o              (erase_kind_o),
        .page_erased_o             (page_erased_o)
    );

    spi_host_model i_spi_host_model (
        .sck_o (sck),
        .cs_n_o(cs_n),
        .si_o  (si)
    );

    always #2.5 ref_clk_i = ~ref_clk_i;

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end

    // dummies driven high so only page bits may count
    function automatic logic [23:0] addr_of(input logic opt264, input logic [9:0] page);
        addr_of = opt264 ? {5'h1F, page, 9'h1FF} : {6'h3F, page, 8'hFF};
    endfunction

    task automatic run_cmd(input string name, input logic opt264, input logic [7:0] op,
                           input logic [9:0] page, input flash_erase_pkg::kind_t kind,
                           input logic [9:0] first, input int count, input int busy_n,
                           input logic fail, input logic extra);
        int strobes;
        int busy;
        int waited;
        strobes = 0;
        busy = 0;
        waited = 0;
        @(posedge ref_clk_i);
        page_264_i <= opt264;
        erase_verify_fail_i <= fail;
        repeat (4) @(posedge ref_clk_i);
        i_spi_host_model.frame({op, addr_of(opt264, page)}, 32);
        if (extra) begin
            fork
                #100 i_spi_host_model.frame({8'h81, addr_of(opt264, 10'h000)}, 32);
            join_none
        end
        while (ready_o === 1'b1 && waited < 8) begin
            @(posedge ref_clk_i);
            #1;
            waited++;
        end
        `CHK(ready_o, 1'b0)
        while (ready_o === 1'b0 && busy < 2000) begin
            if (busy == 0) `CHK(erase_kind_o, kind)
            if (erase_strobe_o === 1'b1) begin
                `CHK(erase_page_o, first + 10'(strobes))
                strobes++;
            end
            busy++;
            @(posedge ref_clk_i);
            #1;
        end
        `CHK(busy, busy_n)
        `CHK(strobes, count)
        `CHK(flag_o, fail)
        @(posedge ref_clk_i);
        page_query_i <= first;
        erase_verify_fail_i <= 1'b0;
        @(posedge ref_clk_i);
        page_query_i <= first + 10'(count - 1);
        #1;
        `CHK(erase_kind_o, flash_erase_pkg::KIND_NONE)
        `CHK(page_erased_o, 1'b1)
        @(posedge ref_clk_i);
        #1;
        `CHK(page_erased_o, 1'b1)
        // a frame sent while busy must be dropped, not queued
        repeat (extra ? 400 : 0) begin
            @(posedge ref_clk_i);
            #1;
            `CHK(ready_o, 1'b1)
        end
        $display("test %s done", name);
    endtask

    task automatic refused(input string name, input logic [31:0] word, input int nbits);
        i_spi_host_model.frame(word, nbits);
        repeat (20) begin
            @(posedge ref_clk_i);
            #1;
            `CHK(ready_o, 1'b1)
        end
        $display("test %s done", name);
    endtask

    initial begin
        // nonblocking falling edge at time zero, so every asynchronous reset branch runs
        reset_n_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        page_query_i <= 10'h3A5;
        repeat (4) @(posedge ref_clk_i);
        #1;
        `CHK(page_erased_o, 1'b0)
        run_cmd("page264", 1, 8'h81, 10'h3A5, flash_erase_pkg::KIND_PAGE, 10'h3A5, 1, PAGE_N, 0, 0);
        run_cmd("page256", 0, 8'h81, 10'h155, flash_erase_pkg::KIND_PAGE, 10'h155, 1, PAGE_N, 1, 0);
        run_cmd("blk256", 0, 8'h50, 10'h3FD, flash_erase_pkg::KIND_BLOCK, 10'h3F8, 8, BLOCK_N, 0, 0);
        run_cmd("blk264", 1, 8'h50, 10'h005, flash_erase_pkg::KIND_BLOCK, 10'h000, 8, BLOCK_N, 1, 0);
        run_cmd("sec0a", 1, 8'h7C, 10'h003, flash_erase_pkg::KIND_SECTOR, 10'h000, 8, SECTOR_N, 0, 0);
        run_cmd("sec0b", 0, 8'h7C, 10'h00B, flash_erase_pkg::KIND_SECTOR, 10'h008, 120, SECTOR_N, 0, 0);
        run_cmd("sec5", 0, 8'h7C, 10'h2C7, flash_erase_pkg::KIND_SECTOR, 10'h280, 128, SECTOR_N, 0, 1);
        run_cmd("sec7", 1, 8'h7C, 10'h3FF, flash_erase_pkg::KIND_SECTOR, 10'h380, 128, SECTOR_N, 0, 0);
        refused("bad_opcode", {8'h52, 24'h000000}, 32);
        refused("short_frame", {8'h81, 24'h000000}, 31);
        // last page of sector 4 sits next to sector 5 and must stay untouched
        @(posedge ref_clk_i);
        page_query_i <= 10'h27F;
        repeat (2) @(posedge ref_clk_i);
        #1;
        `CHK(page_erased_o, 1'b0)
        finish_test();
    end
endmodule

`default_nettype wire
